// ===== pkg/cbcs_defines.vh
`ifndef CBCS_DEFINES_VH
`define CBCS_DEFINES_VH

// ----------------------------------------------------------------------
// Machine cycle kinds requested by the decoder
// ----------------------------------------------------------------------
`define CBCS_KIND_W 3
`define CBCS_K_FETCH 3'h0
`define CBCS_K_MEM_RD 3'h1
`define CBCS_K_MEM_WR 3'h2
`define CBCS_K_IO_RD 3'h3
`define CBCS_K_IO_WR 3'h4
`define CBCS_K_INTA 3'h5

// ----------------------------------------------------------------------
// Cycle lengths in T states, wait states excluded
// ----------------------------------------------------------------------
`define CBCS_FETCH_MIN_T 3'h4
`define CBCS_FETCH_MAX_T 3'h6
`define CBCS_DATA_MIN_T 3'h3
`define CBCS_DATA_MAX_T 3'h5
`define CBCS_IO_AUTO_WAITS 2'h1
`define CBCS_INTA_AUTO_WAITS 2'h2

// ----------------------------------------------------------------------
// Widths and refresh counter fields
// ----------------------------------------------------------------------
`define CBCS_ADDR_W 16
`define CBCS_DATA_W 8
`define CBCS_REFRESH_STROBE_N_LOW_W 7
`define CBCS_REFRESH_STROBE_N_TOP_BIT 7
`define CBCS_REFRESH_STROBE_N_RST 8'h00
`define CBCS_ADDR_RST 16'h0000
`define CBCS_DATA_RST 8'h00

`endif

// ===== verilog/cbcs_refresh_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "cbcs_defines.vh"

// ----------------------------------------------------------------------
// Refresh counter: low seven bits count, top bit keeps its load value
// ----------------------------------------------------------------------
module cbcs_refresh_counter (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire step_i,
  input wire load_i,
  input wire [`CBCS_DATA_W-1:0] load_val_i,
  output reg [`CBCS_DATA_W-1:0] count_o
);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count_o <= `CBCS_REFRESH_STROBE_N_RST;
    end else if (clk_en_i) begin
      if (load_i) begin
        count_o <= load_val_i;
      end else if (step_i) begin
        count_o <= {count_o[`CBCS_REFRESH_STROBE_N_TOP_BIT],
          count_o[`CBCS_REFRESH_STROBE_N_LOW_W-1:0] + 7'h01};
      end
    end
  end

endmodule // cbcs_refresh_counter
`default_nettype wire

// ===== verilog/cbcs_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "cbcs_defines.vh"

module cbcs_sequencer (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // Decoder side
  input wire cyc_start_i,
  input wire [`CBCS_KIND_W-1:0] cyc_kind_i,
  input wire [2:0] cyc_tstates_i,
  input wire cyc_last_i,
  input wire [`CBCS_ADDR_W-1:0] cyc_addr_i,
  input wire [`CBCS_DATA_W-1:0] cyc_wdata_i,
  input wire [`CBCS_DATA_W-1:0] page_i,
  input wire irq_enable_flop_i,
  input wire refresh_strobe_n_load_i,
  input wire [`CBCS_DATA_W-1:0] refresh_strobe_n_load_val_i,
  output wire cyc_ready_o,
  output reg cyc_done_o,
  output reg [`CBCS_DATA_W-1:0] cyc_rdata_o,
  output reg irq_accept_o,
  // Pins
  input wire wait_n_i,
  input wire bus_request_n_i,
  input wire int_n_i,
  input wire [`CBCS_DATA_W-1:0] data_i,
  output reg [`CBCS_ADDR_W-1:0] addr_o,
  output reg addr_oe_n_o,
  output reg [`CBCS_DATA_W-1:0] data_o,
  output reg data_oe_n_o,
  output reg memory_request_n_o,
  output reg io_request_n_o,
  output reg rd_n_o,
  output reg wr_n_o,
  output reg ctrl_oe_n_o,
  output reg refresh_strobe_n_o,
  output reg first_cycle_marker_n_o,
  output reg bus_grant_n_o
);

  // --------------------------------------------------------------------
  // Phase machine: each T state is two clk_sys_i cycles (high, low half)
  // --------------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_T1 = 6'h02;
  localparam [5:0] ST_T2 = 6'h04;
  localparam [5:0] ST_TW = 6'h08;
  localparam [5:0] ST_TX = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg half_r;
  reg [`CBCS_KIND_W-1:0] kind_r;
  reg [2:0] tlen_r;
  reg [2:0] tcnt_r;
  reg [1:0] auto_w_r;
  reg last_r;
  reg wait_seen_r;
  reg breq_r;
  reg [`CBCS_ADDR_W-1:0] pc_r;
  reg [`CBCS_DATA_W-1:0] wdata_r;
  wire [`CBCS_DATA_W-1:0] refresh_strobe_n_cnt;
  wire fetch_like;
  wire cycle_end;
  wire refresh_strobe_n_step;

  // Clamp the requested length into the legal range of the cycle kind
  function [2:0] cbcs_len;
    input [`CBCS_KIND_W-1:0] k;
    input [2:0] t;
    reg [2:0] lo;
    reg [2:0] hi;
    begin
      lo = `CBCS_DATA_MIN_T;
      hi = `CBCS_DATA_MAX_T;
      if (k == `CBCS_K_FETCH || k == `CBCS_K_INTA) begin
        lo = `CBCS_FETCH_MIN_T;
        hi = `CBCS_FETCH_MAX_T;
      end
      if (t < lo) begin
        cbcs_len = lo;
      end else if (t > hi) begin
        cbcs_len = hi;
      end else begin
        cbcs_len = t;
      end
    end
  endfunction

  function cbcs_is_io;
    input [`CBCS_KIND_W-1:0] k;
    begin
      cbcs_is_io = (k == `CBCS_K_IO_RD) || (k == `CBCS_K_IO_WR);
    end
  endfunction

  assign fetch_like = (kind_r == `CBCS_K_FETCH) ||
    (kind_r == `CBCS_K_INTA);
  // Last clock of the cycle: low half of its final T state
  assign cycle_end = (state_r == ST_TX) && half_r && (tcnt_r == tlen_r);
  assign refresh_strobe_n_step = cycle_end && fetch_like;
  // Decoder may issue the next cycle only while idle and bus is ours
  assign cyc_ready_o = (state_r == ST_IDLE) && !breq_r;

  cbcs_refresh_counter u_refresh_strobe_n (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .step_i(refresh_strobe_n_step),
    .load_i(refresh_strobe_n_load_i),
    .load_val_i(refresh_strobe_n_load_val_i),
    .count_o(refresh_strobe_n_cnt)
  );

  // T1 opens on the edge that takes the cycle, before its latches fill
  wire take_now = (state_r == ST_IDLE);
  wire [`CBCS_KIND_W-1:0] kind_eff = take_now ? cyc_kind_i : kind_r;
  wire [`CBCS_ADDR_W-1:0] addr_eff = take_now ? cyc_addr_i : pc_r;
  wire [`CBCS_DATA_W-1:0] wdata_eff = take_now ? cyc_wdata_i : wdata_r;
  wire fetch_eff = (kind_eff == `CBCS_K_FETCH) ||
    (kind_eff == `CBCS_K_INTA);

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (breq_r) begin
          state_nxt = ST_HOLD;
        end else if (cyc_start_i) begin
          state_nxt = ST_T1;
        end
      end
      ST_T1: begin
        if (half_r) begin
          state_nxt = ST_T2;
        end
      end
      ST_T2: begin
        if (half_r) begin
          if (auto_w_r != 2'h0 || wait_seen_r) begin
            state_nxt = ST_TW;
          end else begin
            state_nxt = ST_TX;
          end
        end
      end
      ST_TW: begin
        // Count still holds the automatic wait that is now closing
        if (half_r && auto_w_r <= 2'h1 && !wait_seen_r) begin
          state_nxt = ST_TX;
        end
      end
      ST_TX: begin
        if (cycle_end) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (bus_request_n_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencing registers
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      half_r <= 1'b0;
      kind_r <= `CBCS_K_FETCH;
      tlen_r <= `CBCS_FETCH_MIN_T;
      tcnt_r <= 3'h1;
      auto_w_r <= 2'h0;
      last_r <= 1'b0;
      wait_seen_r <= 1'b0;
      breq_r <= 1'b0;
      pc_r <= `CBCS_ADDR_RST;
      wdata_r <= `CBCS_DATA_RST;
      cyc_done_o <= 1'b0;
      cyc_rdata_o <= `CBCS_DATA_RST;
      irq_accept_o <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      cyc_done_o <= 1'b0;
      irq_accept_o <= 1'b0;
      half_r <= (state_r == ST_IDLE || state_r == ST_HOLD) ? 1'b0 : ~half_r;
      if (state_r == ST_IDLE && !breq_r && cyc_start_i) begin
        kind_r <= cyc_kind_i;
        tlen_r <= cbcs_len(cyc_kind_i, cyc_tstates_i);
        last_r <= cyc_last_i;
        pc_r <= cyc_addr_i;
        wdata_r <= cyc_wdata_i;
        tcnt_r <= 3'h1;
        if (cbcs_is_io(cyc_kind_i)) begin
          auto_w_r <= `CBCS_IO_AUTO_WAITS;
        end else if (cyc_kind_i == `CBCS_K_INTA) begin
          auto_w_r <= `CBCS_INTA_AUTO_WAITS;
        end else begin
          auto_w_r <= 2'h0;
        end
      end
      // Wait line taken at the falling edge of T2 and each wait state
      if ((state_r == ST_T2 || state_r == ST_TW) && !half_r) begin
        wait_seen_r <= !wait_n_i;
      end
      if (half_r && state_r != ST_IDLE && state_r != ST_HOLD) begin
        if (state_r == ST_TW) begin
          if (auto_w_r != 2'h0) begin
            auto_w_r <= auto_w_r - 2'h1;
          end
        end else if (!cycle_end) begin
          tcnt_r <= tcnt_r + 3'h1;
        end
      end
      // Data latched as T3 opens, i.e. as the last wait or T2 closes
      if (half_r && state_nxt == ST_TX && state_r != ST_TX) begin
        cyc_rdata_o <= data_i;
      end
      if (cycle_end) begin
        cyc_done_o <= 1'b1;
        breq_r <= !bus_request_n_i;
        // Ignored when disabled or when the bus is being requested
        irq_accept_o <= last_r && !int_n_i && irq_enable_flop_i &&
          bus_request_n_i;
      end else if (state_r == ST_HOLD && bus_request_n_i) begin
        breq_r <= 1'b0;
      end else if (state_r == ST_IDLE && !bus_request_n_i) begin
        breq_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin drive, registered so every strobe moves on half-state edges
  // --------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_o <= `CBCS_ADDR_RST;
      addr_oe_n_o <= 1'b1;
      data_o <= `CBCS_DATA_RST;
      data_oe_n_o <= 1'b1;
      memory_request_n_o <= 1'b1;
      io_request_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      ctrl_oe_n_o <= 1'b1;
      refresh_strobe_n_o <= 1'b1;
      first_cycle_marker_n_o <= 1'b1;
      bus_grant_n_o <= 1'b1;
    end else if (clk_en_i) begin
      // Default: all strobes idle, address and control ours and driven, data bus released
      memory_request_n_o <= 1'b1;
      io_request_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      refresh_strobe_n_o <= 1'b1;
      first_cycle_marker_n_o <= 1'b1;
      addr_oe_n_o <= 1'b0;
      ctrl_oe_n_o <= 1'b0;
      data_oe_n_o <= 1'b1;
      bus_grant_n_o <= 1'b1;
      case (state_nxt)
        ST_HOLD: begin
          addr_oe_n_o <= 1'b1;
          ctrl_oe_n_o <= 1'b1;
          // Grant follows the float by one clock, never with it
          bus_grant_n_o <= (state_r != ST_HOLD);
        end
        ST_T1, ST_T2, ST_TW: begin
          addr_o <= addr_eff;
          if (fetch_eff || state_nxt != ST_T1) begin
            first_cycle_marker_n_o <= !fetch_eff;
          end
          // Memory strobes open half a state after the address, I/O strobes at T2
          if (state_nxt != ST_T1 || state_r == ST_T1) begin
            if (kind_r == `CBCS_K_INTA) begin
              // Acknowledge waits for the first automatic wait
              io_request_n_o <= (state_nxt != ST_TW);
            end else if (cbcs_is_io(kind_r)) begin
              io_request_n_o <= (state_nxt == ST_T1);
            end else begin
              memory_request_n_o <= 1'b0;
            end
            rd_n_o <= !((kind_r == `CBCS_K_FETCH) ||
              (kind_r == `CBCS_K_MEM_RD) ||
              (kind_r == `CBCS_K_IO_RD && state_nxt != ST_T1));
          end
          if (kind_eff == `CBCS_K_MEM_WR || kind_eff == `CBCS_K_IO_WR) begin
            data_o <= wdata_eff;
            data_oe_n_o <= 1'b0;
            // Write opens only once data has stood a state and a half, two states for I/O
            wr_n_o <= !(state_nxt != ST_T1 && !(state_nxt == ST_T2 &&
              half_r && kind_eff == `CBCS_K_MEM_WR) &&
              !(kind_eff == `CBCS_K_IO_WR && state_nxt == ST_T2));
          end
        end
        ST_TX: begin
          if (fetch_like) begin
            addr_o <= {page_i, refresh_strobe_n_cnt};
            refresh_strobe_n_o <= 1'b0;
            // Request reopens half a state into the refresh slot
            memory_request_n_o <= !(state_r == ST_TX && tcnt_r == 3'h3);
          end else begin
            addr_o <= pc_r;
            // Writes keep the request through the high half of T3, so
            // the closed write strobe leads every bus change
            if (state_r != ST_TX && (kind_r == `CBCS_K_MEM_WR ||
              kind_r == `CBCS_K_IO_WR)) begin
              memory_request_n_o <= cbcs_is_io(kind_r);
              io_request_n_o <= !cbcs_is_io(kind_r);
              wr_n_o <= 1'b1;
            end
            if (kind_r == `CBCS_K_MEM_WR || kind_r == `CBCS_K_IO_WR) begin
              data_o <= wdata_r;
              data_oe_n_o <= 1'b0;
            end
          end
        end
        default: begin
          addr_o <= addr_o;
        end
      endcase
    end
  end

endmodule // cbcs_sequencer
`default_nettype wire

// ===== dv/cbcs_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbcs_defines.vh"
module cbcs_checker (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic cyc_start_i,
  input wire logic [2:0] cyc_kind_i,
  input wire logic [2:0] cyc_tstates_i,
  input wire logic cyc_ready_o,
  input wire logic cyc_done_o,
  input wire logic irq_accept_o,
  input wire logic irq_enable_flop_i,
  input wire logic wait_n_i,
  input wire logic bus_request_n_i,
  input wire logic [15:0] addr_o,
  input wire logic addr_oe_n_o,
  input wire logic memory_request_n_o,
  input wire logic io_request_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic ctrl_oe_n_o,
  input wire logic refresh_strobe_n_o,
  input wire logic first_cycle_marker_n_o,
  input wire logic bus_grant_n_o
);
  // --------------------------------------------
  // Cycle length tracker, in system clocks
  // --------------------------------------------
  logic [5:0] cnt_r;
  logic [5:0] exp_r;
  logic [5:0] exp_nxt;
  logic waited_r;
  logic io_k;
  assign io_k = cyc_kind_i == `CBCS_K_IO_RD || cyc_kind_i == `CBCS_K_IO_WR;
  assign exp_nxt = {2'h0, cyc_tstates_i, 1'b0} +
    (io_k ? 6'h02 : (cyc_kind_i == `CBCS_K_INTA) ? 6'h04 : 6'h00);
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_r <= 6'h00;
      exp_r <= 6'h00;
      waited_r <= 1'b0;
    end else if (cyc_ready_o && cyc_start_i && clk_en_i) begin
      cnt_r <= 6'h00;
      exp_r <= exp_nxt;
      waited_r <= 1'b0;
    end else if (clk_en_i) begin
      cnt_r <= cnt_r + 6'h01;
      if (!wait_n_i) waited_r <= 1'b1;
    end
  end
  // --------------------------------------------
  // Properties
  // --------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_end_req;
    cyc_done_o && !bus_request_n_i;
  endsequence
  sequence s_float;
    ctrl_oe_n_o && addr_oe_n_o;
  endsequence
  cycle_len_a: assert property (cyc_done_o && !waited_r |->
    cnt_r == exp_r) else $error("cycle length wrong");
  wait_len_a: assert property (cyc_done_o && waited_r |->
    cnt_r > exp_r) else $error("wait did not stretch");
  refresh_quiet_a: assert property (!refresh_strobe_n_o |->
    rd_n_o && wr_n_o && io_request_n_o) else $error("strobe in refresh");
  io_not_mem_a: assert property (!io_request_n_o |->
    memory_request_n_o) else $error("io and memory request");
  marker_req_a: assert property ($fell(first_cycle_marker_n_o) |->
    ##[0:8] (!memory_request_n_o || !io_request_n_o))
    else $error("marker without request");
  grant_float_a: assert property (!bus_grant_n_o |-> s_float
    ##0 $past(ctrl_oe_n_o)) else $error("grant while driving");
  bus_request_n_float_a: assert property (s_end_req |->
    ##[1:3] s_float) else $error("bus request not honoured");
  accept_gate_a: assert property (irq_accept_o |->
    cyc_done_o && irq_enable_flop_i && bus_grant_n_o && bus_request_n_i)
    else $error("interrupt accepted wrongly");
  write_hold_a: assert property (!wr_n_o || $rose(wr_n_o) |->
    $stable(addr_o)) else $error("address moved under write");
  read_release_a: assert property ($rose(rd_n_o) |->
    memory_request_n_o && io_request_n_o) else $error("read drop late");
  req_addr_a: assert property ($fell(memory_request_n_o) |->
    $stable(addr_o) && !addr_oe_n_o) else $error("address not settled");
endmodule // cbcs_checker
bind cbcs_sequencer cbcs_checker cbcs_checker_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .cyc_start_i(cyc_start_i), .cyc_kind_i(cyc_kind_i),
  .cyc_tstates_i(cyc_tstates_i), .cyc_ready_o(cyc_ready_o),
  .cyc_done_o(cyc_done_o), .irq_accept_o(irq_accept_o),
  .irq_enable_flop_i(irq_enable_flop_i), .wait_n_i(wait_n_i),
  .bus_request_n_i(bus_request_n_i), .addr_o(addr_o),
  .addr_oe_n_o(addr_oe_n_o), .memory_request_n_o(memory_request_n_o),
  .io_request_n_o(io_request_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
  .ctrl_oe_n_o(ctrl_oe_n_o), .refresh_strobe_n_o(refresh_strobe_n_o),
  .first_cycle_marker_n_o(first_cycle_marker_n_o),
  .bus_grant_n_o(bus_grant_n_o));
`default_nettype wire

// ===== dv/cbcs_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbcs_partner_model #(
  parameter logic [7:0] VECTOR = 8'h3c // Arbitrary vector value
) (
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic [15:0] addr_i,
  input wire logic memory_request_n_i,
  input wire logic io_request_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic first_cycle_marker_n_i,
  input wire logic refresh_strobe_n_i,
  input wire logic [7:0] bus_i,
  output logic [7:0] data_o,
  output logic wait_n_o,
  output logic [7:0] io_last_o
);
  // --------------------------------------------
  // Memory, port and vector source
  // --------------------------------------------
  logic [7:0] mem [0:255];
  logic [7:0] last_r = 8'h00;
  logic [7:0] val;
  logic [7:0] wd_r;
  logic [15:0] wa_r;
  logic [1:0] wcnt_r = 2'h0;
  logic req_d_r = 1'b1;
  logic wpend_r = 1'b0;
  logic wio_r;
  logic drive;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // Vector goes out on request plus marker, as acknowledge has no read
  assign drive = !rd_n_i && (!memory_request_n_i || !io_request_n_i) ||
    !io_request_n_i && !first_cycle_marker_n_i;
  assign val = !io_request_n_i ?
    (!first_cycle_marker_n_i ? VECTOR : ~addr_i[7:0]) : mem[addr_i[7:0]];
  // Released bus shows the inverse of the last driven value so stale data never passes
  assign data_o = drive ? val : ~last_r;
  assign wait_n_o = wcnt_r == 2'h0;
  always @(posedge clk_sys_i) begin
    req_d_r <= memory_request_n_i;
    if (drive) last_r <= val;
    if (slow_i && req_d_r && !memory_request_n_i && refresh_strobe_n_i)
      wcnt_r <= 2'h3;
    else if (wcnt_r != 2'h0)
      wcnt_r <= wcnt_r - 2'h1;
    if (!wr_n_i) begin
      wpend_r <= 1'b1;
      wa_r <= addr_i;
      wd_r <= bus_i;
      wio_r <= !io_request_n_i;
    end else if (wpend_r) begin
      wpend_r <= 1'b0;
      if (wio_r) io_last_o <= wd_r;
      else mem[wa_r[7:0]] <= wd_r;
    end
  end
endmodule // cbcs_partner_model
`default_nettype wire

// ===== dv/tb_cbcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbcs_defines.vh"
module tb_cbcs_sequencer;
  localparam logic [7:0] VEC = 8'h3c;
  logic clk_sys_i = 0, sys_rst_i = 1, cyc_start_i = 0, cyc_last_i = 0;
  logic ien = 0, ld = 0, bus_request_n_i = 1, int_n_i = 1, slow = 0;
  logic [2:0] kind = 0, ts = 3'h4;
  logic [15:0] addr = 0, addr_o;
  logic [7:0] wd = 0, page = 0, ldv = 0, part_d, io_last, data_o;
  logic [7:0] cyc_rdata_o, data_i;
  logic cyc_ready_o, cyc_done_o, irq_accept_o, addr_oe_n_o, data_oe_n_o;
  logic memory_request_n_o, io_request_n_o, rd_n_o, wr_n_o, ctrl_oe_n_o;
  logic refresh_strobe_n_o, first_cycle_marker_n_o, bus_grant_n_o, wait_n;
  int mismatches = 0, total_checks = 0, i;
  logic [9:0] notes [$];
  logic [9:0] n;
  logic [15:0] rfq [$];
  logic [7:0] shadow [0:255];
  logic rf_d = 1;
  assign data_i = data_oe_n_o ? part_d : data_o;
  cbcs_sequencer cbcs_sequencer_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .cyc_start_i(cyc_start_i),
    .cyc_kind_i(kind), .cyc_tstates_i(ts), .cyc_last_i(cyc_last_i),
    .cyc_addr_i(addr), .cyc_wdata_i(wd), .page_i(page),
    .irq_enable_flop_i(ien), .refresh_strobe_n_load_i(ld), .refresh_strobe_n_load_val_i(ldv),
    .cyc_ready_o(cyc_ready_o), .cyc_done_o(cyc_done_o),
    .cyc_rdata_o(cyc_rdata_o), .irq_accept_o(irq_accept_o),
    .wait_n_i(wait_n), .bus_request_n_i(bus_request_n_i),
    .int_n_i(int_n_i), .data_i(data_i), .addr_o(addr_o),
    .addr_oe_n_o(addr_oe_n_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .memory_request_n_o(memory_request_n_o), .io_request_n_o(io_request_n_o),
    .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ctrl_oe_n_o(ctrl_oe_n_o),
    .refresh_strobe_n_o(refresh_strobe_n_o),
    .first_cycle_marker_n_o(first_cycle_marker_n_o),
    .bus_grant_n_o(bus_grant_n_o));
  cbcs_partner_model #(.VECTOR(VEC)) cbcs_partner_model_inst (
    .clk_sys_i(clk_sys_i), .slow_i(slow), .addr_i(addr_o),
    .memory_request_n_i(memory_request_n_o), .io_request_n_i(io_request_n_o),
    .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .bus_i(data_i),
    .first_cycle_marker_n_i(first_cycle_marker_n_o),
    .refresh_strobe_n_i(refresh_strobe_n_o), .data_o(part_d),
    .wait_n_o(wait_n), .io_last_o(io_last));
  // --------------------------------------------
  // Checking and closing
  // --------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [2:0] k, input logic [2:0] t,
      input logic lst, input logic [15:0] a, input logic [7:0] d,
      input logic acc);
    logic [7:0] e;
    e = k == 5 ? VEC : (k == 3 ? ~a[7:0] : shadow[a[7:0]]);
    if (k == `CBCS_K_MEM_WR) shadow[a[7:0]] = d;
    notes.push_back({acc, k == 0 || k == 1 || k == 3 || k == 5, e});
    @(posedge clk_sys_i) #1;
    {cyc_start_i, kind, ts, cyc_last_i, addr, wd} = {1'b1, k, t, lst, a, d};
    for (int j = 0; j < 200; j++) begin
      @(posedge clk_sys_i);
      if (cyc_ready_o === 1'b1) break;
    end
    #1 cyc_start_i = 0;
    for (int j = 0; j < 200 && cyc_done_o !== 1'b1; j++) @(posedge clk_sys_i);
    #1;
  endtask
  always @(posedge clk_sys_i) begin
    if (refresh_strobe_n_o === 0 && memory_request_n_o === 0 && rf_d)
      rfq.push_back(addr_o);
    rf_d = !(refresh_strobe_n_o === 0 && memory_request_n_o === 0);
    if (cyc_done_o === 1'b1) begin
      if (notes.size() == 0) check(16'h1, 16'h0);
      else begin
        n = notes.pop_front();
        check(irq_accept_o, n[9]);
        if (n[8]) check(cyc_rdata_o, n[7:0]);
      end
    end
  end
  // --------------------------------------------
  // Stimulus
  // --------------------------------------------
  initial forever #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #300000;
    mismatches++;
    close_out;
  end
  initial begin
    void'($urandom(32'h4697d36f));
    for (i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h5a;
    repeat (5) @(posedge clk_sys_i);
    #1 sys_rst_i = 0;
    for (i = 0; i < 18; i++) begin
      kind = 3'(i % 6);
      addr = 16'($urandom);
      run(kind, 3'((kind == 0 || kind == 5) ? 4 : 3) + 3'($urandom % 3),
        0, addr, 8'($urandom), 0);
      if (kind == `CBCS_K_MEM_WR) run(1, 3, 0, addr, 0, 0);
      repeat (2) @(posedge clk_sys_i);
      if (kind == `CBCS_K_IO_WR) check(io_last, wd);
    end
    slow = 1;
    run(1, 3, 0, 16'($urandom), 0, 0);
    run(0, 4, 0, 16'($urandom), 0, 0);
    slow = 0;
    {ld, ldv, page} = {1'b1, 8'hfe, 8'($urandom)};
    @(posedge clk_sys_i) #1 ld = 0;
    rfq.delete();
    repeat (3) run(0, 4, 0, 16'($urandom), 0, 0);
    check(16'(rfq.size()), 16'h3);
    for (i = 0; i < 3; i++) begin
      check(rfq[i][15:7], {page, 1'b1});
      if (i > 0) check(rfq[i][6:0], 7'(rfq[i - 1][6:0] + 7'h1));
    end
    {int_n_i, ien} = 2'b01;
    run(0, 4, 1, 16'($urandom), 0, 1);
    run(5, 4, 0, 16'($urandom), 0, 0);
    ien = 0;
    run(0, 5, 1, 16'($urandom), 0, 0);
    ien = 1;
    fork
      run(1, 5, 1, 16'($urandom), 0, 0);
      begin
        repeat (4) @(posedge clk_sys_i);
        #1 bus_request_n_i = 0;
      end
    join
    for (i = 0; i < 50 && bus_grant_n_o !== 0; i++) @(posedge clk_sys_i);
    check(bus_grant_n_o, 0);
    check({addr_oe_n_o, data_oe_n_o, ctrl_oe_n_o}, 3'h7);
    repeat (20) @(posedge clk_sys_i);
    check(cyc_ready_o, 0);
    #1 {bus_request_n_i, int_n_i} = 2'b11;
    for (i = 0; i < 10 && bus_grant_n_o !== 1; i++) @(posedge clk_sys_i);
    #1 check({bus_grant_n_o, addr_oe_n_o, ctrl_oe_n_o}, 3'h4);
    run(1, 3, 0, 16'($urandom), 0, 0);
    close_out;
  end
endmodule // tb_cbcs_sequencer
`default_nettype wire
